// ### tct_regs.vh
// Constants for the thermal clock throttle block
// Overview of operation
// - On-demand enable starts clock gating once the phase reaches the duty
// - On-demand duty follows three-bit eighths field, zero taken as one eighth
// - Thermal gate duty overrides on-demand duty
// - Alert asserted at max temperature, gate active
// - Interrupt on alert assert, deassert or both
// - External low alert activates thermal gate
// - Catastrophic temperature latches shutdown output
// - Shutdown independent of activity, no bus cycles
// - Fan threshold factory value, 00h to 1Eh
// - Gate modulates until cool and hysteresis expires
`ifndef TCT_REGS_VH
`define TCT_REGS_VH
// -----------------------------------------------------------
// Control field positions
// -----------------------------------------------------------
`define TCT_OD_EN_BIT 4
`define TCT_DUTY_MSB 3
`define TCT_DUTY_LSB 1
// -----------------------------------------------------------
// Factory values and timing
// -----------------------------------------------------------
`define TCT_TCC_DUTY 3'h3
`define TCT_FAN_THRESH 5'h14
`define TCT_FAN_THRESH_MAX 5'h1E
`define TCT_FAN_BASE_C 7'h32
`define TCT_MOD_STEP 8'h3F
`define TCT_HYST_US 20
`define TCT_CLK_MHZ 50
// Hysteresis of 20 us at the 50 MHz clock, in cycles
`define TCT_HYST_CYC 11'h3E8
`define TCT_INT_RISE 2'h1
`define TCT_INT_FALL 2'h2
`endif

// ### tct_sync.v
// Two-stage synchroniser for one level
`timescale 1ns/100ps
module tct_sync
(
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Data
   input wire d_i,
   input wire rst_val_i,
   output reg q_o
);
   reg meta;
   // Capture then settle; meta is read only by q_o
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= 1'b0;
         q_o <= 1'b0;
      end
      else
      begin
         meta <= d_i ^ rst_val_i;
         q_o <= meta;
      end
   end
endmodule // tct_sync

// ### tct_throttle.v
// Thermal clock throttle: on-demand and thermal modulation, alert, shutdown
`timescale 1ns/100ps
`include "tct_regs.vh"
module tct_throttle
(
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Software control
   input wire [4:0] throttle_control_i,
   input wire tm_enable_i,
   input wire [1:0] int_sel_i,
   input wire int_clear_i,
   // Thermal sensors (asynchronous)
   input wire max_temp_i,
   input wire cat_temp_i,
   // Bidirectional alert pin, active low
   input wire thermal_alert_n_i,
   output wire thermal_alert_n_o,
   output wire thermal_alert_n_oe_o,
   // Status and outputs
   output reg core_clk_en_o,
   output reg thermal_clock_gate_o,
   output reg alert_int_o,
   output reg overtemp_shutdown_n_o,
   output wire [4:0] fan_threshold_temp_o
);
   // -----------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------
   wire hot_s;
   wire cat_s;
   wire ext_hot_s;
   // Die at its operating limit
   tct_sync u_hot
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .d_i(max_temp_i),
      .rst_val_i(1'b0),
      .q_o(hot_s)
   );
   // Catastrophic sensor, read whatever the monitor setting
   tct_sync u_cat
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .d_i(cat_temp_i),
      .rst_val_i(1'b0),
      .q_o(cat_s)
   );
   // Inverted so an idle high pin reads as not hot
   tct_sync u_ext
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .d_i(thermal_alert_n_i),
      .rst_val_i(1'b1),
      .q_o(ext_hot_s)
   );

   // -----------------------------------------------------------
   // Alert pin drive
   // -----------------------------------------------------------
   // Open drain: data fixed low, the enable carries the level
   // drive alert low
   assign thermal_alert_n_o = 1'b0;
   assign thermal_alert_n_oe_o = hot_s;
   // The cap keeps a bad factory value inside the legal range
   // factory fan threshold, capped
   assign fan_threshold_temp_o = (`TCT_FAN_THRESH > `TCT_FAN_THRESH_MAX) ?
      `TCT_FAN_THRESH_MAX : `TCT_FAN_THRESH;

   // -----------------------------------------------------------
   // Thermal gate with hysteresis
   // -----------------------------------------------------------
   localparam [10:0] HYST_CYC = `TCT_HYST_CYC;
   reg [10:0] hyst_cnt;
   // Alert seen low when we or the board assert it
   wire alert_act = hot_s | ext_hot_s;
   wire gate_req = tm_enable_i & alert_act;
   // Hold the gate until cool for the hysteresis time;
   // the reload on every hot cycle stops rapid on/off toggling
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         thermal_clock_gate_o <= 1'b0;
         hyst_cnt <= 11'h000;
      end
      else if (gate_req)
      begin
         thermal_clock_gate_o <= 1'b1;
         hyst_cnt <= HYST_CYC;
      end
      else if (thermal_clock_gate_o)
      begin
         if (hyst_cnt <= 11'h001)
         begin
            thermal_clock_gate_o <= 1'b0;
         end
         hyst_cnt <= (hyst_cnt == 11'h000) ? 11'h000 : hyst_cnt - 11'h001;
      end
   end

   // -----------------------------------------------------------
   // Modulation timing: step enable and eighth phase
   // -----------------------------------------------------------
   // One step is 64 cycles, eight steps make one period
   reg [7:0] step_cnt;
   reg [2:0] phase;
   wire step_en = (step_cnt == `TCT_MOD_STEP);
   // Free-running step counter and phase
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         step_cnt <= 8'h00;
         phase <= 3'h0;
      end
      else
      begin
         step_cnt <= step_en ? 8'h00 : step_cnt + 8'h01;
         if (step_en)
         begin
            phase <= phase + 3'h1;
         end
      end
   end

   // -----------------------------------------------------------
   // Core clock enable
   // -----------------------------------------------------------
   wire od_en = throttle_control_i[`TCT_OD_EN_BIT];
   wire [2:0] od_duty = throttle_control_i[`TCT_DUTY_MSB:`TCT_DUTY_LSB];
   // Either source asks for modulation
   wire mod_req = od_en | thermal_clock_gate_o;
   // A trip stops the core at once, on the same edge that the latch sets
   wire run_ok = overtemp_shutdown_n_o & ~cat_s;
   reg [2:0] duty;
   reg next_clk_en;
   always @*
   begin
      if (thermal_clock_gate_o)
      begin
         duty = `TCT_TCC_DUTY;
      end
      else
      begin
         duty = (od_duty == 3'h0) ? 3'h1 : od_duty;
      end
      if (mod_req)
      begin
         next_clk_en = (phase < duty);
      end
      else
      begin
         next_clk_en = 1'b1;
      end
   end
   // Registered clock enable; shutdown stops the core
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         core_clk_en_o <= 1'b1;
      end
      else
      begin
         core_clk_en_o <= next_clk_en & run_ok;
      end
   end

   // -----------------------------------------------------------
   // Catastrophic shutdown latch
   // -----------------------------------------------------------
   // Only reset releases it; nothing in the core is involved
   // latch shutdown, no bus activity
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         overtemp_shutdown_n_o <= 1'b1;
      end
      else if (cat_s)
      begin
         overtemp_shutdown_n_o <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // Alert edge interrupt
   // -----------------------------------------------------------
   reg alert_d;
   wire rise = alert_act & ~alert_d;
   wire fall = ~alert_act & alert_d;
   // Edges that software has chosen to hear
   wire rise_hit = rise & ((int_sel_i & `TCT_INT_RISE) != 2'h0);
   wire fall_hit = fall & ((int_sel_i & `TCT_INT_FALL) != 2'h0);
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         alert_d <= 1'b0;
         alert_int_o <= 1'b0;
      end
      else
      begin
         alert_d <= alert_act;
         // A clear in the cycle of a new edge must not lose it
         if (rise_hit | fall_hit)
         begin
            alert_int_o <= 1'b1;
         end
         else if (int_clear_i)
         begin
            alert_int_o <= 1'b0;
         end
      end
   end
endmodule // tct_throttle

// ### tct_throttle_chk.sv
// Assertion checker for the thermal clock throttle ports
`timescale 1ns/100ps
module tct_throttle_chk
(
   // Inputs
   input wire ref_clk_i,
   input wire rst_i,
   input wire [4:0] throttle_control_i,
   input wire tm_enable_i,
   input wire [1:0] int_sel_i,
   input wire max_temp_i,
   input wire cat_temp_i,
   input wire thermal_alert_n_i,
   // Outputs
   input wire thermal_alert_n_oe_o,
   input wire core_clk_en_o,
   input wire thermal_clock_gate_o,
   input wire alert_int_o,
   input wire overtemp_shutdown_n_o
);
   // Common clock and reset
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Alert line held low with the monitor on
   sequence s_low; (!thermal_alert_n_i && tm_enable_i) [*4]; endsequence
   property p_od; $rose(throttle_control_i[4]) && !thermal_clock_gate_o
      |-> ##[1:520] !core_clk_en_o; endproperty
   property p_hot; $rose(max_temp_i) |-> ##[1:3] thermal_alert_n_oe_o; endproperty
   property p_gate; s_low |-> thermal_clock_gate_o; endproperty
   property p_up; $fell(thermal_alert_n_i) && int_sel_i[0] |-> ##[1:4] alert_int_o; endproperty
   property p_dn; $rose(thermal_alert_n_i) && int_sel_i[1] |-> ##[1:4] alert_int_o; endproperty
   property p_trip; $rose(cat_temp_i) |-> ##[1:4] !overtemp_shutdown_n_o; endproperty
   property p_hold; !overtemp_shutdown_n_o |=> !overtemp_shutdown_n_o; endproperty
   property p_stop; !overtemp_shutdown_n_o |=> !core_clk_en_o; endproperty
   a_od: assert property (p_od) else $error("no gating");
   a_hot: assert property (p_hot) else $error("alert not driven");
   a_gate: assert property (p_gate) else $error("gate idle");
   a_up: assert property (p_up) else $error("no assert irq");
   a_dn: assert property (p_dn) else $error("no release irq");
   a_trip: assert property (p_trip) else $error("no shutdown");
   a_hold: assert property (p_hold) else $error("shutdown lost");
   a_stop: assert property (p_stop) else $error("clock runs");
endmodule // tct_throttle_chk
bind tct_throttle tct_throttle_chk chk (.*);

// ### tct_board.sv
// Board model: pulled-up alert wire, regulator monitor, fan control
`timescale 1ns/100ps
module tct_board
(
   // Device side
   input wire alert_oe_i,
   input wire alert_d_i,
   input wire [4:0] fan_threshold_temp_i,
   // Board side
   input wire vr_hot_i,
   input wire [6:0] diode_temperature_i,
   output wire thermal_alert_n_o,
   output wire fan_full_o
);
   assign thermal_alert_n_o = !((alert_oe_i && !alert_d_i) || vr_hot_i);
   assign fan_full_o = diode_temperature_i >= {2'h0, fan_threshold_temp_i} + 7'h32;
endmodule // tct_board

// ### tct_throttle_tb.sv
// Self-checking bench for the thermal clock throttle
`timescale 1ns/100ps
`include "tct_regs.vh"
module tct_throttle_tb;
   reg ref_clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [4:0] ctl = 5'h00;
   reg [1:0] sel = 2'h0;
   reg tm = 1'b0, clr = 1'b0, hot = 1'b0, cat = 1'b0, vr = 1'b0;
   reg [6:0] tdio = 7'h00;
   reg [9:0] n;
   wire pin, a_d, a_oe, clk_en, gate, irq, shut_n, full;
   wire [4:0] fan;
   integer err_total = 0;
   integer checked = 0;
   integer d;
   // Clock
   always #10 ref_clk_i = ~ref_clk_i;
   tct_throttle dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .throttle_control_i(ctl),
      .tm_enable_i(tm), .int_sel_i(sel), .int_clear_i(clr), .max_temp_i(hot),
      .cat_temp_i(cat), .thermal_alert_n_i(pin), .thermal_alert_n_o(a_d),
      .thermal_alert_n_oe_o(a_oe), .core_clk_en_o(clk_en), .thermal_clock_gate_o(gate),
      .alert_int_o(irq), .overtemp_shutdown_n_o(shut_n), .fan_threshold_temp_o(fan));
   tct_board board (.alert_oe_i(a_oe), .alert_d_i(a_d), .fan_threshold_temp_i(fan),
      .vr_hot_i(vr), .diode_temperature_i(tdio), .thermal_alert_n_o(pin), .fan_full_o(full));
   task cyc(input integer c);
      begin
         repeat (c) @(posedge ref_clk_i);
         #2;
      end
   endtask
   // Compare a one-bit output level
   task chk_bit(input got, input exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            err_total = err_total + 1;
            $display("BAD %0t level %b want %b", $time, got, exp);
         end
      end
   endtask
   // Compare a count of running cycles or a field value
   task chk_cnt(input [9:0] got, input [9:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            err_total = err_total + 1;
            $display("BAD %0t got %0d want %0d", $time, got, exp);
         end
      end
   endtask
   // Count running clock cycles over one modulation period
   task on_cnt;
      begin
         n = 10'h000;
         repeat (512)
         begin
            cyc(1);
            n = n + clk_en;
         end
      end
   endtask
   task results;
      begin
         if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // Reset held 12 cycles, then two cycles to settle
   task sc_reset;
      begin
         rst_i = 1'b1;
         cyc(12);
         rst_i = 1'b0;
         cyc(2);
      end
   endtask
   // On-demand duty sweep, then free running
   task sc_ondemand;
      begin
         for (d = 0; d < 8; d = d + 1)
         begin
            ctl = {1'b1, d[2:0], 1'b0};
            cyc(8);
            on_cnt;
            chk_cnt(n, (d == 0) ? 10'h040 : {d[3:0], 6'h00});
         end
         ctl = 5'h00;
         cyc(4);
         on_cnt;
         chk_cnt(n, 10'h200);
      end
   endtask
   // Board pulls the alert low while on-demand asks for 7/8
   task sc_board_hot;
      begin
         {tm, sel, ctl, vr} = {1'b1, 2'h3, 5'h1E, 1'b1};
         cyc(5);
         chk_bit(gate, 1'b1);
         chk_bit(irq, 1'b1);
         clr = 1'b1;
         cyc(1);
         clr = 1'b0;
         cyc(1);
         chk_bit(irq, 1'b0);
         on_cnt;
         chk_cnt(n, {1'b0, `TCT_TCC_DUTY, 6'h00});
         vr = 1'b0;
         cyc(990);
         chk_bit(gate, 1'b1);
         cyc(30);
         chk_bit(gate, 1'b0);
         chk_bit(irq, 1'b1);
      end
   endtask
   // Die at its limit drives the alert and the gate
   task sc_die_hot;
      begin
         {ctl, sel, clr, hot} = {5'h00, 2'h0, 1'b1, 1'b1};
         cyc(5);
         clr = 1'b0;
         chk_bit(pin, 1'b0);
         chk_bit(gate, 1'b1);
         hot = 1'b0;
         cyc(1100);
         chk_bit(irq, 1'b0);
         chk_bit(pin, 1'b1);
         chk_bit(gate, 1'b0);
      end
   endtask
   // Interrupt on one selected edge only
   task sc_edge_sel;
      begin
         {sel, hot} = {2'h1, 1'h1};
         cyc(8);
         chk_bit(irq, 1'b1);
         clr = 1'b1;
         cyc(1);
         {clr, hot} = 2'h0;
         cyc(8);
         chk_bit(irq, 1'b0);
         {sel, hot} = {2'h2, 1'h1};
         cyc(8);
         chk_bit(irq, 1'b0);
         hot = 1'b0;
         cyc(8);
         chk_bit(irq, 1'b1);
         {sel, clr} = {2'h0, 1'h1};
         cyc(1);
         clr = 1'b0;
      end
   endtask
   // Fan threshold read and compared with base added
   task sc_fan;
      begin
         tdio = `TCT_FAN_THRESH + 7'h31;
         cyc(1);
         chk_bit(full, 1'b0);
         tdio = `TCT_FAN_THRESH + 7'h32;
         cyc(1);
         chk_bit(full, 1'b1);
         chk_cnt({5'h00, fan}, {5'h00, `TCT_FAN_THRESH});
      end
   endtask
   // Catastrophic trip latches until a reset in mid-run
   task sc_trip;
      begin
         cat = 1'b1;
         cyc(3);
         cat = 1'b0;
         cyc(50);
         chk_bit(shut_n, 1'b0);
         chk_bit(clk_en, 1'b0);
         sc_reset;
         chk_bit(shut_n, 1'b1);
         chk_bit(clk_en, 1'b1);
      end
   endtask
   // Scenarios
   initial
   begin
      sc_reset;
      sc_ondemand;
      sc_board_hot;
      sc_die_hot;
      sc_edge_sel;
      sc_fan;
      sc_trip;
      results;
   end
endmodule // tct_throttle_tb
